// *** hps_pkg.sv ***
// Package with timing constants and state types of the hot-swap sequencer
package hps_pkg;
  // ==========================================================
  // Clock
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned CLK_NS = 20;
  // ==========================================================
  // Printed times
  localparam int unsigned INSERTION_DELAY_US = 13700;
  localparam int unsigned DISCHARGE_HOLD_US = 4660;
  localparam int unsigned STARTUP_TIMEOUT_MS = 215;
  localparam int unsigned OVERVOLTAGE_RESPONSE_NS = 1570;
  localparam int unsigned BLANKING_SHORT_US = 400;
  localparam int unsigned BLANKING_LONG_US = 3200;
  localparam int unsigned RETRY_DELAY_MS = 105;
  // ==========================================================
  // Cycle counts derived from the times
  localparam int unsigned INSERTION_DELAY_CYC =
    INSERTION_DELAY_US * (CLK_HZ / 1000000);
  localparam int unsigned DISCHARGE_HOLD_CYC =
    DISCHARGE_HOLD_US * (CLK_HZ / 1000000);
  localparam int unsigned STARTUP_TIMEOUT_CYC =
    STARTUP_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned OVERVOLTAGE_RESPONSE_CYC =
    OVERVOLTAGE_RESPONSE_NS / CLK_NS;
  localparam int unsigned BLANKING_SHORT_CYC =
    BLANKING_SHORT_US * (CLK_HZ / 1000000);
  localparam int unsigned BLANKING_LONG_CYC =
    BLANKING_LONG_US * (CLK_HZ / 1000000);
  localparam int unsigned RETRY_DELAY_CYC =
    RETRY_DELAY_MS * (CLK_HZ / 1000);
  // ==========================================================
  // Counter width and sequencer states
  localparam int unsigned CNT_W = 24;
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned NUM_IN = 9;
  typedef enum logic [2:0] {
    HPS_OFF, HPS_INSERT, HPS_WAIT_EN, HPS_START, HPS_ON, HPS_FAULT
  } hps_state_t;
endpackage

// *** hps_rail_load.sv ***
// Supply rail and load model facing the hot-swap sequencer
`timescale 1ns/10ps
module hps_rail_load #(
  parameter int RAMP = 2000
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic fet_enable,
  input wire logic [1:0] supply,
  input wire logic [1:0] load,
  output logic vin_above_uv,
  output logic vin_above_ov_rise,
  output logic vin_above_ov_fall,
  output logic startup_complete,
  output logic over_ocp,
  output logic over_scaled_fast_trip,
  output logic over_fixed_fast_trip
);
  // ==========================================================
  // Comparators
  int ramp_cnt;
  // Supply codes: 0 absent, 1 nominal, 2 overvoltage
  assign vin_above_uv = (supply != 2'h0);
  assign vin_above_ov_rise = (supply == 2'h2);
  assign vin_above_ov_fall = (supply == 2'h2);
  // Load current flows only through a conducting FET
  assign over_ocp = fet_enable && (load != 2'h0);
  assign over_scaled_fast_trip = fet_enable && (load == 2'h2);
  assign over_fixed_fast_trip = fet_enable && (load == 2'h2);
  // ==========================================================
  // Output ramp: full turn-on some cycles after FET enable
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ramp_cnt <= 0;
    end else if (!fet_enable) begin
      ramp_cnt <= 0;
    end else if (ramp_cnt < RAMP) begin
      ramp_cnt <= ramp_cnt + 1;
    end
  end
  // Load code 3 is a start-up that never reaches full turn-on
  assign startup_complete = fet_enable && (ramp_cnt >= RAMP) &&
    (load != 2'h3);
endmodule // hps_rail_load

// *** hps_sequencer.sv ***
// Hot-swap protection sequencer top level
`timescale 1ns/10ps
// Functional notes
// RULE1 - The FET stays off while the input is under either undervoltage level.
// RULE2 - In the middle enable band the FET is off but state is kept.
// RULE3 - Staying in the middle band past the hold time starts discharge.
// RULE4 - Below the shutdown level everything resets, latched faults included.
// RULE5 - After supply comes good the FET waits an insertion delay.
// RULE6 - Input overvoltage switches the FET off within the response time.
// RULE7 - When overvoltage clears the FET restarts softly with no latch.
// RULE8 - A start-up exceeding its timeout raises a fault and latch or retry.
// RULE9 - Overcurrent is the comparator of sense against 0.75 of reference.
// RULE10 - Overcurrent under the short level starts the blanking timer.
// RULE11 - Overcurrent ending before blanking expiry causes no trip.
// RULE12 - Overcurrent lasting the full blanking interval trips the FET.
// RULE13 - After a fault the device latches off or retries after a delay.
// RULE14 - Scaled fast trip always applies, fixed fast trip in steady state.
// RULE15 - Current limit acts in start-up, breaker only in steady state.
// RULE16 - Every interval is a counter that restarts when its cause ends.
module hps_sequencer #(
  parameter int unsigned INS_CYC = hps_pkg::INSERTION_DELAY_CYC,
  parameter int unsigned QOD_CYC = hps_pkg::DISCHARGE_HOLD_CYC,
  parameter int unsigned SUT_CYC = hps_pkg::STARTUP_TIMEOUT_CYC,
  parameter int unsigned BLANK_SHORT_CYC = hps_pkg::BLANKING_SHORT_CYC,
  parameter int unsigned BLANK_LONG_CYC = hps_pkg::BLANKING_LONG_CYC,
  parameter int unsigned RETRY_CYC = hps_pkg::RETRY_DELAY_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic vin_above_uv,
  input wire logic vin_above_ov_rise,
  input wire logic vin_above_ov_fall,
  input wire logic enable_above_uvlo,
  input wire logic enable_above_shutdown,
  input wire logic startup_complete,
  input wire logic over_ocp,
  input wire logic over_scaled_fast_trip,
  input wire logic over_fixed_fast_trip,
  input wire logic auto_retry_sel,
  input wire logic long_blanking_sel,
  output logic fet_enable,
  output logic current_limit_active,
  output logic output_discharge,
  output logic bias_enable,
  output logic fault_indicator_n
);
  // ==========================================================
  // Input synchronisers
  logic [hps_pkg::NUM_IN-1:0] raw_in;
  logic [hps_pkg::NUM_IN-1:0] sync1;
  logic [hps_pkg::NUM_IN-1:0] sync2;
  logic uv_ok, ov_hi, ov_lo_hi, en_on, en_alive, su_done;
  logic oc, sft, fft;

  assign raw_in = {vin_above_uv, vin_above_ov_rise, vin_above_ov_fall,
                   enable_above_uvlo, enable_above_shutdown,
                   startup_complete, over_ocp, over_scaled_fast_trip, // RULE9
                   over_fixed_fast_trip};

  // Two-flop chain on every pin input
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
    end
  end

  assign {uv_ok, ov_hi, ov_lo_hi, en_on, en_alive, su_done, oc, sft, fft}
    = sync2;

  // ==========================================================
  // Strap selects
  logic [1:0] sel_sync1;
  logic [1:0] sel_sync2;
  logic auto_retry, long_blank;

  // Straps are pins as well, so they pass the same two flops
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sel_sync1 <= '0;
      sel_sync2 <= '0;
    end else begin
      sel_sync1 <= {auto_retry_sel, long_blanking_sel};
      sel_sync2 <= sel_sync1;
    end
  end

  assign {auto_retry, long_blank} = sel_sync2;

  // ==========================================================
  // Overvoltage hysteresis flag
  logic ov_active;

  // Set above rising level, clear below falling level
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ov_active <= 1'b0;
    end else if (!en_alive) begin
      ov_active <= 1'b0;
    end else if (ov_hi) begin
      ov_active <= 1'b1; // RULE6
    end else if (!ov_lo_hi) begin
      ov_active <= 1'b0; // RULE7
    end
  end

  // ==========================================================
  // Interval timers
  hps_pkg::hps_state_t state;
  logic ins_done, qod_done, su_to, blank_done, retry_done;
  logic mid_band, oc_window;
  logic [hps_pkg::CNT_W-1:0] blank_limit;

  assign mid_band = en_alive && !en_on;
  // Breaker window only in steady state, below the short level
  assign oc_window = (state == hps_pkg::HPS_ON) && oc && !sft && !fft; // RULE10
  assign blank_limit = long_blank ?
    hps_pkg::CNT_W'(BLANK_LONG_CYC) :
    hps_pkg::CNT_W'(BLANK_SHORT_CYC);

  hps_timer u_ins (
    .ref_clk(ref_clk), .nrst(nrst),
    .run(state == hps_pkg::HPS_INSERT),
    .limit(hps_pkg::CNT_W'(INS_CYC)),
    .done(ins_done));
  hps_timer u_qod (
    .ref_clk(ref_clk), .nrst(nrst), .run(mid_band),
    .limit(hps_pkg::CNT_W'(QOD_CYC)),
    .done(qod_done));
  hps_timer u_sut (
    .ref_clk(ref_clk), .nrst(nrst),
    .run(state == hps_pkg::HPS_START && !ov_active),
    .limit(hps_pkg::CNT_W'(SUT_CYC)),
    .done(su_to));
  hps_timer u_blank (
    .ref_clk(ref_clk), .nrst(nrst), .run(oc_window), // RULE11
    .limit(blank_limit), .done(blank_done));
  hps_timer u_retry (
    .ref_clk(ref_clk), .nrst(nrst),
    .run(state == hps_pkg::HPS_FAULT && auto_retry),
    .limit(hps_pkg::CNT_W'(RETRY_CYC)),
    .done(retry_done));

  // ==========================================================
  // Sequencer
  hps_pkg::hps_state_t next_state;
  logic fast_trip;

  // Scaled trip always, fixed trip only in steady state
  assign fast_trip = sft || (fft && state == hps_pkg::HPS_ON); // RULE14

  // Next-state selection
  always_comb begin
    next_state = state;
    case (state)
      hps_pkg::HPS_OFF: begin
        if (uv_ok && en_alive) next_state = hps_pkg::HPS_INSERT;
      end
      hps_pkg::HPS_INSERT: begin
        if (!uv_ok) next_state = hps_pkg::HPS_OFF;
        else if (ins_done) next_state = hps_pkg::HPS_WAIT_EN; // RULE5
      end
      hps_pkg::HPS_WAIT_EN: begin
        if (!uv_ok) next_state = hps_pkg::HPS_OFF; // RULE1
        else if (en_on && !ov_active) next_state = hps_pkg::HPS_START;
      end
      hps_pkg::HPS_START: begin
        if (!uv_ok || !en_on) next_state = hps_pkg::HPS_WAIT_EN; // RULE1
        else if (su_to || fast_trip) next_state = hps_pkg::HPS_FAULT; // RULE8
        else if (ov_active) next_state = hps_pkg::HPS_WAIT_EN;
        else if (su_done) next_state = hps_pkg::HPS_ON;
      end
      hps_pkg::HPS_ON: begin
        if (!uv_ok || !en_on) next_state = hps_pkg::HPS_WAIT_EN; // RULE2
        else if (blank_done || fast_trip) next_state = hps_pkg::HPS_FAULT; // RULE12
        else if (ov_active) next_state = hps_pkg::HPS_WAIT_EN; // RULE7
      end
      hps_pkg::HPS_FAULT: begin
        if (retry_done) next_state = hps_pkg::HPS_WAIT_EN; // RULE13
      end
      default: next_state = hps_pkg::HPS_OFF;
    endcase
  end

  // State register, shutdown band clears everything
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= hps_pkg::HPS_OFF;
    end else if (!en_alive) begin
      state <= hps_pkg::HPS_OFF; // RULE4
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Outputs from flip-flops
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fet_enable <= 1'b0;
      current_limit_active <= 1'b0;
      output_discharge <= 1'b0;
      bias_enable <= 1'b0;
      fault_indicator_n <= 1'b1;
    end else begin
      fet_enable <= (next_state == hps_pkg::HPS_START ||
                     next_state == hps_pkg::HPS_ON) && en_alive &&
                    !ov_hi; // RULE6
      current_limit_active <= (next_state == hps_pkg::HPS_START); // RULE15
      output_discharge <= qod_done; // RULE3
      bias_enable <= en_alive; // RULE2
      fault_indicator_n <= !(next_state == hps_pkg::HPS_FAULT &&
                             en_alive); // RULE8
    end
  end

  // ==========================================================
  // Checks
  property p_ov_off;
    @(posedge ref_clk) disable iff (!nrst)
      ov_hi |=> !fet_enable;
  endproperty
  a_ov_off: assert property (p_ov_off) // RULE6
    else $error("fet on during overvoltage");

  property p_shutdown;
    @(posedge ref_clk) disable iff (!nrst)
      !en_alive |=> (state == hps_pkg::HPS_OFF) && fault_indicator_n;
  endproperty
  a_shutdown: assert property (p_shutdown) // RULE4
    else $error("shutdown did not clear state");

  property p_uv_off;
    @(posedge ref_clk) disable iff (!nrst)
      !uv_ok |=> !fet_enable;
  endproperty
  a_uv_off: assert property (p_uv_off) // RULE1
    else $error("fet on under undervoltage");

  property p_mid_off;
    @(posedge ref_clk) disable iff (!nrst)
      mid_band |=> !fet_enable && bias_enable;
  endproperty
  a_mid_off: assert property (p_mid_off) // RULE2
    else $error("middle band handling wrong");

  property p_qod;
    @(posedge ref_clk) disable iff (!nrst)
      $rose(qod_done) |=> output_discharge;
  endproperty
  a_qod: assert property (p_qod) // RULE3
    else $error("discharge not started");

  property p_ins;
    @(posedge ref_clk) disable iff (!nrst)
      $rose(state == hps_pkg::HPS_INSERT) |-> !fet_enable [*8];
  endproperty
  a_ins: assert property (p_ins) // RULE5
    else $error("fet on during insertion delay");

  property p_trip;
    @(posedge ref_clk) disable iff (!nrst)
      (blank_done && state == hps_pkg::HPS_ON && en_on && uv_ok)
        |=> !fault_indicator_n;
  endproperty
  a_trip: assert property (p_trip) // RULE12
    else $error("breaker did not trip");

  property p_limit;
    @(posedge ref_clk) disable iff (!nrst)
      current_limit_active |-> !oc_window;
  endproperty
  a_limit: assert property (p_limit) // RULE15
    else $error("breaker active during start-up");

  property p_latch;
    @(posedge ref_clk) disable iff (!nrst)
      (state == hps_pkg::HPS_FAULT && !auto_retry && en_alive)
        |=> state == hps_pkg::HPS_FAULT;
  endproperty
  a_latch: assert property (p_latch) // RULE13
    else $error("latched fault released");

  property p_retry;
    @(posedge ref_clk) disable iff (!nrst)
      (retry_done && state == hps_pkg::HPS_FAULT && en_alive)
        |=> state == hps_pkg::HPS_WAIT_EN && fault_indicator_n;
  endproperty
  a_retry: assert property (p_retry) // RULE13
    else $error("retry did not restart");

  property p_sut;
    @(posedge ref_clk) disable iff (!nrst)
      (su_to && state == hps_pkg::HPS_START && en_on && uv_ok && en_alive)
        |=> !fet_enable && !fault_indicator_n;
  endproperty
  a_sut: assert property (p_sut) // RULE8
    else $error("start-up timeout not flagged");

  property p_fast;
    @(posedge ref_clk) disable iff (!nrst)
      (sft && state == hps_pkg::HPS_ON && en_on && uv_ok && en_alive)
        |=> !fet_enable && !fault_indicator_n;
  endproperty
  a_fast: assert property (p_fast) // RULE14
    else $error("fast trip did not turn off");
endmodule // hps_sequencer

// *** hps_timer.sv ***
// Restartable interval counter with a done flag
`timescale 1ns/10ps
module hps_timer (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic [hps_pkg::CNT_W-1:0] limit,
  output logic done
);
  logic [hps_pkg::CNT_W-1:0] count;

  // Count while qualified, restart when not
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
    end else if (!run) begin
      count <= '0; // RULE16
    end else if (count < limit) begin
      count <= count + 1'b1;
    end
  end

  assign done = run && (count >= limit);
endmodule // hps_timer

// *** testbench.sv ***
// Self-checking testbench of the hot-swap sequencer
`timescale 1ns/10ps
module testbench;
  // ==========================================================
  // Signals
  // Shortened intervals keep the run brief; roughly twice the test length
  localparam int WDOG = 40000;
  localparam int RAMP = 200;
  localparam int INS = 3000;
  localparam int QOD = 1000;
  localparam int SUT = 1000;
  localparam int BS = 500;
  localparam int BL = 1500;
  localparam int RET = 2000;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic enable_undervoltage_input = 1'b0;
  logic en_sd = 1'b0;
  logic [1:0] supply = 2'h0;
  logic [1:0] load = 2'h0;
  logic retry_sel = 1'b0;
  logic blank_long = 1'b0;
  logic uv, ovr, ovf, su_done, ocp, sft, fft;
  logic fet, lim, dis, bias, flt_n;
  int n_mismatch = 0;
  int n_checks = 0;
  // Clock of 20 ns period
  always #10 ref_clk = ~ref_clk;
  // ==========================================================
  // Design and far side
  hps_rail_load #(.RAMP(RAMP)) i_rail (.ref_clk(ref_clk), .nrst(nrst),
    .fet_enable(fet), .supply(supply), .load(load), .vin_above_uv(uv),
    .vin_above_ov_rise(ovr), .vin_above_ov_fall(ovf),
    .startup_complete(su_done), .over_ocp(ocp),
    .over_scaled_fast_trip(sft), .over_fixed_fast_trip(fft));
  hps_sequencer #(.INS_CYC(INS), .QOD_CYC(QOD), .SUT_CYC(SUT),
    .BLANK_SHORT_CYC(BS), .BLANK_LONG_CYC(BL), .RETRY_CYC(RET))
    i_dut (.ref_clk(ref_clk), .nrst(nrst),
    .vin_above_uv(uv), .vin_above_ov_rise(ovr), .vin_above_ov_fall(ovf),
    .enable_above_uvlo(enable_undervoltage_input), .enable_above_shutdown(en_sd),
    .startup_complete(su_done), .over_ocp(ocp),
    .over_scaled_fast_trip(sft), .over_fixed_fast_trip(fft),
    .auto_retry_sel(retry_sel), .long_blanking_sel(blank_long),
    .fet_enable(fet), .current_limit_active(lim),
    .output_discharge(dis), .bias_enable(bias),
    .fault_indicator_n(flt_n));
  // ==========================================================
  // Helpers
  task automatic run(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic chk(input logic seen, input logic exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_power_up;
    en_sd = 1'b1;
    enable_undervoltage_input = 1'b1;
    run(100);
    chk(fet, 1'b0);
    supply = 2'h1;
    run(INS);
    chk(fet, 1'b0);
    run(10);
    chk(fet, 1'b1);
    chk(lim, 1'b1);
    run(RAMP + 20);
    chk(lim, 1'b0);
    chk(flt_n, 1'b1);
  endtask
  task automatic t_overvoltage;
    supply = 2'h2;
    run(int'(hps_pkg::OVERVOLTAGE_RESPONSE_CYC));
    chk(fet, 1'b0);
    supply = 2'h1;
    run(10);
    chk(fet, 1'b1);
    chk(lim, 1'b1);
    chk(flt_n, 1'b1);
    run(RAMP + 20);
  endtask
  task automatic t_overcurrent;
    load = 2'h1;
    run(BS - 100);
    load = 2'h0;
    run(10);
    chk(fet, 1'b1);
    load = 2'h1;
    run(BS - 10);
    chk(fet, 1'b1);
    run(30);
    chk(fet, 1'b0);
    chk(flt_n, 1'b0);
  endtask
  task automatic t_latch_clear;
    load = 2'h0;
    run(RET + 100);
    chk(fet, 1'b0);
    chk(flt_n, 1'b0);
    en_sd = 1'b0;
    run(10);
    chk(flt_n, 1'b1);
    chk(bias, 1'b0);
  endtask
  task automatic t_middle_band;
    enable_undervoltage_input = 1'b0;
    en_sd = 1'b1;
    run(10);
    chk(bias, 1'b1);
    run(QOD - 20);
    chk(dis, 1'b0);
    run(30);
    chk(dis, 1'b1);
    chk(fet, 1'b0);
    enable_undervoltage_input = 1'b1;
    run(INS);
    chk(fet, 1'b1);
    chk(dis, 1'b0);
    run(RAMP + 20);
    load = 2'h2;
    run(10);
    chk(fet, 1'b0);
    chk(flt_n, 1'b0);
  endtask
  task automatic t_retry;
    retry_sel = 1'b1;
    load = 2'h3;
    run(RET - 10);
    chk(fet, 1'b0);
    run(20);
    chk(fet, 1'b1);
    chk(flt_n, 1'b1);
    run(SUT - 20);
    chk(flt_n, 1'b1);
    run(30);
    chk(fet, 1'b0);
    chk(flt_n, 1'b0);
  endtask
  task automatic t_long_blank;
    blank_long = 1'b1;
    load = 2'h1;
    run(RET + RAMP + BL - 100);
    chk(fet, 1'b1);
    run(200);
    chk(fet, 1'b0);
    chk(flt_n, 1'b0);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    run(4);
    nrst = 1'b1;
    t_power_up();
    t_overvoltage();
    t_overcurrent();
    t_latch_clear();
    t_middle_band();
    t_retry();
    t_long_blank();
    stop_test();
  end
  // Watchdog against a hang
  initial begin
    repeat (WDOG) @(posedge ref_clk);
    n_mismatch++;
    stop_test();
  end
endmodule // testbench
